/* File: rtl/qrvs_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - above supply turn-on threshold, stop start-up charging and begin switching.
// - soft-start is 12 ms in 4 steps, limit rising from 0.32 V to 1 V.
// - turn-on from zero crossings and skip count; turn-off from sense comparison.
// - up/down counter holds how many crossings to skip before turn-on.
// - feedback compared and up/down counter updated once per 48 ms period.
// - feedback always below lower threshold: count up, stopping at 7.
// - feedback above lower but never above upper threshold: hold value.
// - feedback above upper but never above reset threshold: count down to 1.
// - feedback ever above reset threshold: force counter straight to 1.
// - counter stays within 1 to 7; steps leaving that range are ignored.
// - counter loads 1 at start-up for full load capability.
// - lower and upper thresholds are chosen by detected line level.
// - zero-crossing counter is bounded between 0 and 7.
// - after turn-off each falling crossing through 100 mV adds one.
// - zero-crossing counter clears each time the gate goes high.
// - overvoltage on zero-crossing input during off-time latches off after blanking.
// - after ringing suppression, turn on once crossings reach skip count.
// - gate off for the maximum off period turns on regardless.
// - ringing suppression is long below select threshold, short otherwise.
// - scaled current above feedback resets the gate flip-flop.
module qrvs_ctrl #(
   parameter int EVAL_CYC = qrvs_pkg::EVAL_CYC,
   parameter int SS_STEP_CYC = qrvs_pkg::SS_STEP_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire qrvs_pkg::qrvs_cmp_t cmp_raw,
   output logic gate_drive,
   output logic startup_charge_en,
   output logic [2:0] cs_limit_level,
   output logic soft_start_done,
   output logic threshold_line_sel,
   output logic latched_off,
   output logic [2:0] skip_count,
   output logic [2:0] zc_count
);
   localparam int CW = qrvs_pkg::CNT_W;

   qrvs_pkg::qrvs_cmp_t cmp_meta;
   qrvs_pkg::qrvs_cmp_t cmp;
   qrvs_pkg::qrvs_fb_t fb_bus;
   qrvs_pkg::qrvs_state_t state;
   qrvs_pkg::qrvs_state_t next_state;
   logic zc_prev;
   logic [CW-1:0] on_cnt;
   logic [CW-1:0] off_cnt;
   logic [CW-1:0] ovp_cnt;
   logic [CW-1:0] ring_len;
   logic eval_tick;

   // decode of the synchronised comparator decisions
   wire logic run = state == qrvs_pkg::ST_RUN;
   wire logic zc_fall = zc_prev && !cmp.zc_zero;
   wire logic ring_done = off_cnt >= ring_len;
   wire logic max_off_hit = off_cnt >= qrvs_pkg::MAX_OFF_CYC;
   wire logic valley_ok = ring_done && zc_count >= skip_count;
   wire logic turn_on = run && !gate_drive && (valley_ok || max_off_hit);
   wire logic leb_done = on_cnt >= qrvs_pkg::LEB_CYC;
   wire logic turn_off = gate_drive && leb_done &&
      (cmp.cs_fb || cmp.cs_limit);
   wire logic ovp_seen = run && !gate_drive && cmp.zc_ovp;
   wire logic ovp_trip = ovp_seen &&
      ovp_cnt >= qrvs_pkg::OVP_BLANK_CYC - 12'h001;
   wire logic zc_step = run && !gate_drive && zc_fall &&
      zc_count < qrvs_pkg::ZC_MAX;

   assign ring_len = cmp.zc_rs_low ? qrvs_pkg::RING_LONG_CYC :
      qrvs_pkg::RING_SHORT_CYC;
   assign fb_bus = '{above_low: cmp.fb_low, above_high: cmp.fb_high,
      above_reset: cmp.fb_reset};
   assign startup_charge_en = state == qrvs_pkg::ST_CHARGE;
   assign latched_off = state == qrvs_pkg::ST_LATCH;
   assign threshold_line_sel = cmp.line_high;

   // two-stage synchroniser for all comparator inputs
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cmp_meta <= '0;
         cmp <= '0;
         zc_prev <= 1'b0;
      end
      else
      begin
         cmp_meta <= cmp_raw;
         cmp <= cmp_meta;
         zc_prev <= cmp.zc_zero;
      end
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         qrvs_pkg::ST_CHARGE:
            if (cmp.vcc_on)
               next_state = qrvs_pkg::ST_RUN;
         qrvs_pkg::ST_RUN:
            if (ovp_trip)
               next_state = qrvs_pkg::ST_LATCH;
         qrvs_pkg::ST_LATCH:
            next_state = qrvs_pkg::ST_LATCH;
         default:
            next_state = qrvs_pkg::ST_CHARGE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         state <= qrvs_pkg::ST_CHARGE;
      else
         state <= next_state;
   end

   // gate flip-flop: set by valley logic, reset by sense comparators
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || next_state != qrvs_pkg::ST_RUN)
         gate_drive <= 1'b0;
      else if (turn_on)
         gate_drive <= 1'b1;
      else if (turn_off)
         gate_drive <= 1'b0;
   end

   // on-time counter for leading-edge blanking
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !gate_drive)
         on_cnt <= '0;
      else if (!leb_done)
         on_cnt <= on_cnt + 12'h001;
   end

   // off-time counter; preset so the first switching cycle starts at once
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || state == qrvs_pkg::ST_CHARGE)
         off_cnt <= qrvs_pkg::MAX_OFF_CYC;
      else if (gate_drive)
         off_cnt <= '0;
      else if (!max_off_hit)
         off_cnt <= off_cnt + 12'h001;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !run)
         zc_count <= qrvs_pkg::ZC_MIN;
      else if (turn_on)
         zc_count <= qrvs_pkg::ZC_MIN;
      else if (zc_step)
         zc_count <= zc_count + 3'h1;
   end

   // overvoltage blanking counter, restarts whenever the condition drops
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !ovp_seen)
         ovp_cnt <= '0;
      else if (!ovp_trip)
         ovp_cnt <= ovp_cnt + 12'h001;
   end

   qrvs_updown #(
      .EVAL_CYC(EVAL_CYC)
   ) u_updown (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .run(run),
      .fb(fb_bus),
      .skip_count(skip_count),
      .eval_tick(eval_tick)
   );

   qrvs_softstart #(
      .STEP_CYC(SS_STEP_CYC)
   ) u_softstart (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .run(run),
      .level(cs_limit_level),
      .done(soft_start_done)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_start_switching;
      ##1 !startup_charge_en ##1 gate_drive;
   endsequence

   sequence s_latch_off;
      ##1 latched_off && !gate_drive ##1 latched_off && !gate_drive;
   endsequence

   sequence s_still_off;
      ##1 !gate_drive;
   endsequence

   sequence s_blanking;
      gate_drive && !leb_done;
   endsequence

   a_no_gate_charge:
   assert property (state == qrvs_pkg::ST_CHARGE |->
      !gate_drive && startup_charge_en)
      else $error("gate active while charging");
   a_start_switch:
   assert property (state == qrvs_pkg::ST_CHARGE && cmp.vcc_on |->
      s_start_switching)
      else $error("switching did not begin after turn-on");
   a_zc_clear_rise:
   assert property ($rose(gate_drive) |-> zc_count == qrvs_pkg::ZC_MIN)
      else $error("crossing count not cleared at gate rise");
   a_zc_count_up:
   assert property (zc_step && !turn_on |=>
      zc_count == $past(zc_count) + 3'h1)
      else $error("falling crossing not counted");
   a_zc_saturate:
   assert property (run && zc_count == qrvs_pkg::ZC_MAX && !turn_on &&
      next_state == qrvs_pkg::ST_RUN |=> zc_count == qrvs_pkg::ZC_MAX)
      else $error("crossing count left its ceiling");
   a_valley_on:
   assert property (run && !gate_drive && valley_ok && !ovp_trip |=>
      gate_drive)
      else $error("valley reached but gate stayed off");
   a_no_early_on:
   assert property ($rose(gate_drive) |-> $past(max_off_hit) ||
      ($past(off_cnt) >= $past(ring_len) &&
      $past(zc_count) >= $past(skip_count)))
      else $error("gate turned on too early");
   a_max_off_on:
   assert property (run && !gate_drive && max_off_hit && !ovp_trip |=>
      gate_drive)
      else $error("maximum off period did not force turn-on");
   a_leb_min_on:
   assert property ($rose(gate_drive) && !ovp_trip |-> gate_drive [*8])
      else $error("gate on shorter than blanking time");
   a_cs_turn_off:
   assert property (gate_drive && leb_done && cmp.cs_fb |=> !gate_drive)
      else $error("current above feedback did not turn off");
   a_ovp_latch:
   assert property (ovp_trip |-> s_latch_off)
      else $error("overvoltage did not latch off");
   a_ovp_blank:
   assert property ($rose(latched_off) |->
      $past(ovp_cnt) == qrvs_pkg::OVP_BLANK_CYC - 12'h001)
      else $error("latch-off before blanking expired");

   a_ring_refuse:
   assert property (run && !gate_drive && !ring_done && !max_off_hit |->
      s_still_off)
      else $error("gate turned on during ringing suppression");
   a_skip_refuse:
   assert property (run && !gate_drive && zc_count < skip_count &&
      !max_off_hit |-> s_still_off)
      else $error("gate turned on before enough crossings");
   a_blank_hold:
   assert property (s_blanking |=> gate_drive)
      else $error("gate turned off inside blanking time");
   a_cs_limit_off:
   assert property (gate_drive && leb_done && cmp.cs_limit |=>
      !gate_drive)
      else $error("current limit did not turn off");
   a_zc_hold_on:
   assert property (gate_drive |=> $stable(zc_count))
      else $error("crossing counted while gate on");
   a_ovp_ignored_on:
   assert property (gate_drive |=> ovp_cnt == '0)
      else $error("overvoltage counted while gate on");
   a_ovp_wait:
   assert property (ovp_seen && !ovp_trip |=> !latched_off)
      else $error("latch-off before blanking count");
   a_charge_wait:
   assert property (startup_charge_en && !cmp.vcc_on |=>
      startup_charge_en && !gate_drive)
      else $error("charging ended without supply turn-on");
   a_latch_stay:
   assert property (latched_off |=> latched_off && !gate_drive)
      else $error("latch-off released");
   a_ss_charge_level:
   assert property (startup_charge_en |->
      cs_limit_level == qrvs_pkg::SS_LVL_START)
      else $error("soft-start level not at start while charging");
   a_skip_loaded:
   assert property (startup_charge_en |->
      skip_count == qrvs_pkg::SKIP_MIN)
      else $error("up/down counter not loaded with one");
   a_off_cnt_cap:
   assert property (off_cnt <= qrvs_pkg::MAX_OFF_CYC)
      else $error("off counter beyond maximum off period");
   a_gate_needs_run:
   assert property (!run |-> !gate_drive)
      else $error("gate active outside switching state");
   a_first_on:
   assert property ($fell(startup_charge_en) |=> gate_drive)
      else $error("first switching cycle did not start");
endmodule : qrvs_ctrl

/* File: rtl/qrvs_pkg.sv */
package qrvs_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_NS = 25;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int EVAL_MS = 48;
   localparam int EVAL_CYC = EVAL_MS * CYC_PER_MS;
   localparam int SS_MS = 12;
   localparam int SS_STEPS = 4;
   localparam int SS_STEP_CYC = SS_MS * CYC_PER_MS / SS_STEPS;
   localparam int LEB_NS = 220;
   localparam int RING_LONG_NS = 3000;
   localparam int RING_SHORT_NS = 1000;
   localparam int MAX_OFF_NS = 50000;
   localparam int OVP_BLANK_NS = 1000;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] LEB_CYC =
      CNT_W'((LEB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RING_LONG_CYC =
      CNT_W'((RING_LONG_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RING_SHORT_CYC =
      CNT_W'((RING_SHORT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] MAX_OFF_CYC =
      CNT_W'(MAX_OFF_NS / CLK_NS);
   localparam logic [CNT_W-1:0] OVP_BLANK_CYC =
      CNT_W'((OVP_BLANK_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [2:0] SKIP_MIN = 3'h1;
   localparam logic [2:0] SKIP_MAX = 3'h7;
   localparam logic [2:0] ZC_MIN = 3'h0;
   localparam logic [2:0] ZC_MAX = 3'h7;
   localparam logic [2:0] SS_LVL_START = 3'h0;
   localparam logic [2:0] SS_LVL_FINAL = 3'h4;

   typedef struct packed {
      logic vcc_on;
      logic fb_low;
      logic fb_high;
      logic fb_reset;
      logic cs_fb;
      logic cs_limit;
      logic zc_zero;
      logic zc_ovp;
      logic zc_rs_low;
      logic line_high;
   } qrvs_cmp_t;

   typedef struct packed {
      logic above_low;
      logic above_high;
      logic above_reset;
   } qrvs_fb_t;

   typedef enum logic [1:0] {
      ST_CHARGE = 2'b00,
      ST_RUN = 2'b01,
      ST_LATCH = 2'b10
   } qrvs_state_t;
endpackage : qrvs_pkg

/* File: rtl/qrvs_updown.sv */
`timescale 1ns/1ps
module qrvs_updown #(
   parameter int EVAL_CYC = qrvs_pkg::EVAL_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic run,
   input wire qrvs_pkg::qrvs_fb_t fb,
   output logic [2:0] skip_count,
   output logic eval_tick
);
   localparam int PW = $clog2(EVAL_CYC + 1);
   localparam logic [PW-1:0] LAST = PW'(EVAL_CYC - 1);
   logic [PW-1:0] period;
   qrvs_pkg::qrvs_fb_t seen;
   qrvs_pkg::qrvs_fb_t seen_all;
   logic [2:0] next_skip;
   wire logic can_up = skip_count < qrvs_pkg::SKIP_MAX;
   wire logic can_down = skip_count > qrvs_pkg::SKIP_MIN;

   assign eval_tick = run && period == LAST;
   assign seen_all = seen | fb;

   always_comb
   begin
      next_skip = skip_count;
      if (seen_all.above_reset)
         next_skip = qrvs_pkg::SKIP_MIN;
      else if (seen_all.above_high)
      begin
         if (can_down)
            next_skip = skip_count - 3'h1;
      end
      else if (!seen_all.above_low && can_up)
         next_skip = skip_count + 3'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !run)
      begin
         period <= '0;
         seen <= '0;
         skip_count <= qrvs_pkg::SKIP_MIN;
      end
      else if (eval_tick)
      begin
         period <= '0;
         seen <= '0;
         skip_count <= next_skip;
      end
      else
      begin
         period <= period + 1'b1;
         seen <= seen_all;
      end
   end

   a_ud_reset_one:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      eval_tick && seen_all.above_reset |=>
      skip_count == qrvs_pkg::SKIP_MIN)
      else $error("counter not forced to one");
   a_ud_count_up:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      eval_tick && seen_all == '0 && can_up |=>
      skip_count == $past(skip_count) + 3'h1)
      else $error("counter did not count up");
   a_ud_hold:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      eval_tick && seen_all.above_low && !seen_all.above_high &&
      !seen_all.above_reset |=> $stable(skip_count))
      else $error("counter changed in hold band");
   a_ud_count_down:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      eval_tick && seen_all.above_high && !seen_all.above_reset &&
      can_down |=> skip_count == $past(skip_count) - 3'h1)
      else $error("counter did not count down");
   a_ud_range:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      skip_count >= qrvs_pkg::SKIP_MIN && skip_count <= qrvs_pkg::SKIP_MAX)
      else $error("counter out of range");
   a_ud_period:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && $past(run) && $changed(skip_count) |-> $past(eval_tick))
      else $error("counter changed off the period boundary");
endmodule : qrvs_updown

/* File: rtl/qrvs_softstart.sv */
`timescale 1ns/1ps
module qrvs_softstart #(
   parameter int STEP_CYC = qrvs_pkg::SS_STEP_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic run,
   output logic [2:0] level,
   output logic done
);
   localparam int PW = $clog2(STEP_CYC + 1);
   localparam logic [PW-1:0] LAST = PW'(STEP_CYC - 1);
   logic [PW-1:0] cnt;
   wire logic step_end = run && !done && cnt == LAST;

   assign done = level == qrvs_pkg::SS_LVL_FINAL;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !run)
      begin
         cnt <= '0;
         level <= qrvs_pkg::SS_LVL_START;
      end
      else if (step_end)
      begin
         cnt <= '0;
         level <= level + 3'h1;
      end
      else if (!done)
         cnt <= cnt + 1'b1;
   end

   a_ss_step_time:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && $past(run) && $changed(level) |-> $past(cnt) == LAST)
      else $error("soft-start step of wrong length");
   a_ss_rising:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && $past(run) |->
      level == $past(level) || level == $past(level) + 3'h1)
      else $error("soft-start level did not rise one step");
   a_ss_final:
   assert property (@(posedge clk_sys) disable iff (sys_rst)
      done && run |=> done || !run)
      else $error("soft-start left final level");
endmodule : qrvs_softstart

/* File: bench/qrvs_flyback.sv */
`timescale 1ns/1ps
module qrvs_flyback (
   input wire logic clk_sys,
   input wire logic gate_drive,
   input wire logic vcc_up,
   input wire logic [1:0] fb_lvl,
   input wire logic ovp_req,
   input wire logic rs_low,
   input wire logic line_hi,
   input wire logic [3:0] ring_n,
   input wire logic [7:0] on_len,
   input wire logic cs_lim,
   output qrvs_pkg::qrvs_cmp_t cmp
);
   logic [11:0] on_cyc = 12'h0;
   logic [11:0] off_cyc = 12'h0;

   // on and off time of the switch as seen by the winding
   always_ff @(posedge clk_sys)
   begin
      on_cyc <= gate_drive ? on_cyc + 12'h1 : 12'h0;
      off_cyc <= gate_drive ? 12'h0 : off_cyc + {11'h0, off_cyc != 12'hfff};
   end

   assign cmp.vcc_on = vcc_up;
   assign cmp.fb_low = fb_lvl >= 2'h1;
   assign cmp.fb_high = fb_lvl >= 2'h2;
   assign cmp.fb_reset = fb_lvl == 2'h3;
   // ramp reaches feedback after on_len cycles
   assign cmp.cs_fb = gate_drive && on_cyc >= {4'h0, on_len};
   // current limit trips at a fixed point of the ramp when enabled
   assign cmp.cs_limit = gate_drive && cs_lim && on_cyc >= 12'h010;
   // ringing of ring_n periods of 16 cycles, then damped out
   assign cmp.zc_zero = !gate_drive && !off_cyc[3]
      && off_cyc < {4'h0, ring_n, 4'h0};
   assign cmp.zc_ovp = ovp_req && !gate_drive;
   assign cmp.zc_rs_low = rs_low;
   assign cmp.line_high = line_hi;
endmodule : qrvs_flyback

/* File: bench/qrvs_ctrl_tb.sv */
`timescale 1ns/1ps
module qrvs_ctrl_tb;
   localparam int EVAL_T = 64;
   localparam int SS_T = 32;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic vcc_up = 1'b0;
   logic [1:0] fb_lvl = 2'h0;
   logic ovp_req = 1'b0;
   logic rs_low = 1'b0;
   logic line_hi = 1'b0;
   logic [3:0] ring_n = 4'h3;
   logic [7:0] on_len = 8'h1e;
   logic cs_lim = 1'b0;
   qrvs_pkg::qrvs_cmp_t cmp;
   logic gate_drive, startup_charge_en, soft_start_done;
   logic threshold_line_sel, latched_off;
   logic [2:0] cs_limit_level, skip_count, zc_count;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   logic [2:0] zl;

   always #12.5 clk_sys = ~clk_sys;

   qrvs_flyback far (.clk_sys(clk_sys), .gate_drive(gate_drive),
      .vcc_up(vcc_up), .fb_lvl(fb_lvl), .ovp_req(ovp_req), .rs_low(rs_low),
      .line_hi(line_hi), .ring_n(ring_n), .on_len(on_len), .cs_lim(cs_lim),
      .cmp(cmp));

   qrvs_ctrl #(.EVAL_CYC(EVAL_T), .SS_STEP_CYC(SS_T)) dut (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .cmp_raw(cmp), .gate_drive(gate_drive),
      .startup_charge_en(startup_charge_en), .cs_limit_level(cs_limit_level),
      .soft_start_done(soft_start_done),
      .threshold_line_sel(threshold_line_sel), .latched_off(latched_off),
      .skip_count(skip_count), .zc_count(zc_count));

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input int lo, input int hi,
      input logic [11:0] got);
      n_compared++;
      if ($isunknown(got) || int'(got) < lo || int'(got) > hi)
      begin
         fails++;
         $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk

   task automatic ticks(input int k);
      repeat (k) @(negedge clk_sys);
   endtask : ticks

   // length of the next whole phase of the gate at level lvl
   task automatic meas(input logic lvl, output int len, output logic [2:0] z);
      len = 0;
      while (gate_drive === lvl && len < 4000)
      begin
         ticks(1);
         len++;
      end
      while (gate_drive !== lvl && len < 8000)
      begin
         ticks(1);
         len++;
      end
      len = 0;
      z = zc_count;
      while (gate_drive === lvl && len < 4000)
      begin
         z = zc_count;
         ticks(1);
         len++;
      end
   endtask : meas

   task automatic next_skip(input logic [2:0] exp);
      logic [2:0] old;
      int i;
      old = skip_count;
      i = 0;
      while (skip_count === old && i < 2 * EVAL_T)
      begin
         ticks(1);
         i++;
      end
      chk("skip_count", exp, exp, 12'(skip_count));
   endtask : next_skip

   task automatic t_reset;
      chk("startup_charge_en", 1, 1, 12'(startup_charge_en));
      chk("gate_drive", 0, 0, 12'(gate_drive));
      chk("skip_count", 1, 1, 12'(skip_count));
      chk("zc_count", 0, 0, 12'(zc_count));
      chk("latched_off", 0, 0, 12'(latched_off));
      chk("cs_limit_level", 0, 0, 12'(cs_limit_level));
   endtask : t_reset

   task automatic t_start;
      int i;
      vcc_up = 1'b1;
      for (i = 0; i < 10 && startup_charge_en !== 1'b0; i++)
         ticks(1);
      chk("charge off delay", 2, 4, 12'(i));
      for (i = 0; i < 4 && gate_drive !== 1'b1; i++)
         ticks(1);
      chk("first gate delay", 0, 2, 12'(i));
      for (int k = 1; k <= 4; k++)
      begin
         for (i = 0; i < 2 * SS_T && cs_limit_level !== 3'(k - 1); i++)
            ticks(1);
         for (i = 0; i < 2 * SS_T && cs_limit_level === 3'(k - 1); i++)
            ticks(1);
         chk("soft start level", k, k, 12'(cs_limit_level));
         if (k > 1)
            chk("soft start step", SS_T, SS_T, 12'(i));
      end
      chk("soft_start_done", 1, 1, 12'(soft_start_done));
   endtask : t_start

   task automatic t_updown;
      for (int k = 0; k < 7 && skip_count !== 3'h7; k++)
         next_skip(skip_count + 3'h1);
      ticks(EVAL_T + 3);
      chk("skip at max", 7, 7, 12'(skip_count));
      fb_lvl = 2'h2;
      next_skip(3'h6);
      ticks(EVAL_T - 8);
      fb_lvl = 2'h1;
      next_skip(3'h5);
      ticks(EVAL_T + 3);
      chk("skip hold", 5, 5, 12'(skip_count));
      fb_lvl = 2'h3;
      next_skip(3'h1);
      fb_lvl = 2'h2;
      ticks(EVAL_T + 3);
      chk("skip at min", 1, 1, 12'(skip_count));
   endtask : t_updown

   task automatic t_valley;
      meas(1'b0, n, zl);
      chk("short ring off", 40, 46, 12'(n));
      chk("crossings at turn on", 1, 7, 12'(zl));
      chk("zc after turn on", 0, 0, 12'(zc_count));
      meas(1'b1, n, zl);
      chk("on time", 31, 36, 12'(n));
      rs_low = 1'b1;
      on_len = 8'h2;
      meas(1'b0, n, zl);
      meas(1'b0, n, zl);
      chk("long ring off", 120, 126, 12'(n));
      meas(1'b1, n, zl);
      chk("blanked on time", 10, 13, 12'(n));
      on_len = 8'h1e;
      cs_lim = 1'b1;
      meas(1'b1, n, zl);
      chk("limited on time", 18, 21, 12'(n));
      cs_lim = 1'b0;
      rs_low = 1'b0;
      fb_lvl = 2'h0;
      for (int k = 0; k < 7 && skip_count !== 3'h7; k++)
         next_skip(skip_count + 3'h1);
      fb_lvl = 2'h1;
      meas(1'b0, n, zl);
      meas(1'b0, n, zl);
      chk("max off time", 2000, 2006, 12'(n));
      chk("crossings counted", 3, 3, 12'(zl));
      ring_n = 4'h9;
      meas(1'b0, n, zl);
      meas(1'b0, n, zl);
      chk("seventh valley off", 104, 112, 12'(n));
      chk("crossings capped", 7, 7, 12'(zl));
      ring_n = 4'h3;
   endtask : t_valley

   task automatic t_line;
      line_hi = 1'b1;
      ticks(4);
      chk("threshold_line_sel", 1, 1, 12'(threshold_line_sel));
      line_hi = 1'b0;
      ticks(4);
      chk("threshold_line_sel", 0, 0, 12'(threshold_line_sel));
   endtask : t_line

   task automatic t_ovp;
      int i;
      for (i = 0; i < 4000 && gate_drive !== 1'b1; i++)
         ticks(1);
      for (i = 0; i < 4000 && gate_drive !== 1'b0; i++)
         ticks(1);
      ticks(5);
      ovp_req = 1'b1;
      ticks(20);
      ovp_req = 1'b0;
      ticks(50);
      chk("latched_off glitch", 0, 0, 12'(latched_off));
      ovp_req = 1'b1;
      for (i = 0; i < 60 && latched_off !== 1'b1; i++)
         ticks(1);
      chk("latch delay", 40, 45, 12'(i));
      ovp_req = 1'b0;
      ticks(100);
      chk("gate while latched", 0, 0, 12'(gate_drive));
      chk("latched_off", 1, 1, 12'(latched_off));
      sys_rst = 1'b1;
      ticks(2);
      sys_rst = 1'b0;
      ticks(1);
      chk("latched_off reset", 0, 0, 12'(latched_off));
      chk("skip after reset", 1, 1, 12'(skip_count));
   endtask : t_ovp

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         end_sim();
      end
   end

   initial
   begin
      ticks(8);
      sys_rst = 1'b0;
      ticks(1);
      t_reset();
      t_start();
      t_updown();
      t_valley();
      t_line();
      t_ovp();
      end_sim();
   end
endmodule : qrvs_ctrl_tb
